/* design/bfm_pkg.sv */
// Shared constants and types for the burst and deviation controller.
package bfm_pkg;
    // ------------------------------------------------------------
    // Frequencies, all in millihertz, and error codes
    // ------------------------------------------------------------
    localparam int FW = 40;
    localparam logic [FW-1:0] DEV_MIN   = 40'd10;
    localparam logic [FW-1:0] DEV_MAX   = 40'd7_500_000_000;
    localparam logic [FW-1:0] DEV_RESET = 40'd100_000;
    localparam logic [FW-1:0] LIM_SINE  = 40'd15_100_000_000;
    localparam logic [FW-1:0] LIM_TRI   = 40'd200_000_000;
    localparam logic [FW-1:0] LIM_ARB   = 40'd5_100_000_000;
    localparam logic [15:0] ERR_CONFLICT = -16'sd221;
    localparam logic [15:0] ERR_NONE     = 16'h0000;
    // ------------------------------------------------------------
    // Burst field widths
    // ------------------------------------------------------------
    localparam int CW = 24;
    localparam int RW = 32;
    localparam int PW = 12;
    localparam int LW = 3;

    typedef enum logic [2:0] {
        SHP_SINE = 3'h0, SHP_SQUARE = 3'h1, SHP_TRI = 3'h2,
        SHP_RAMP = 3'h3, SHP_ARB = 3'h4, SHP_OTHER = 3'h7
    } bfm_shape_t;

    typedef enum logic [2:0] {
        MOD_NONE = 3'h0, MOD_AM = 3'h1, MOD_FM = 3'h2,
        MOD_FSK = 3'h3, MOD_BURST = 3'h4
    } bfm_mod_t;

    typedef enum logic [2:0] {
        TRG_IMMEDIATE = 3'h0, TRG_INTERNAL = 3'h1, TRG_BUS = 3'h2,
        TRG_EXTERNAL = 3'h3, TRG_BACKPLANE = 3'h4
    } bfm_trig_t;

    typedef enum logic [1:0] {
        BST_IDLE = 2'b00, BST_RUN = 2'b01, BST_GATE = 2'b11
    } bfm_state_t;

    typedef struct packed {
        logic             gatedMode;
        bfm_trig_t        triggerSourceSelect;
        logic [LW-1:0]    backplaneTriggerLine;
        logic [CW-1:0]    burstCycleCount;
        logic [RW-1:0]    burstRepeatRate;
        logic [PW-1:0]    burstStartPhase;
    } bfm_burst_cfg_t;
endpackage

/* design/bfm_burst_fm_ctrl.sv */
// Deviation clamping, modulation selection and burst engine.
`timescale 1ns/10ps
// Operation
// - Deviation accepted from 10 mHz to 7.5 MHz; 100 Hz after reset.
// - With FM on, deviation above carrier becomes carrier, error -221.
// - Carrier plus deviation capped at shape maximum plus 100 kHz, error.
// - One modulation at a time; burst enable turns others off.
// - Burst works for sine, square, triangle, ramp and arbitrary shapes.
// - Burst mode select picks counted or gated bursts.
// - Counted burst starts on timer, external, backplane or bus trigger.
// - Counted burst runs exactly the programmed cycles, one if zero, then waits.
// - Internal trigger repeats bursts at the programmed repetition rate.
// - Gated output starts on gate high, ends on gate low.
// - Gate low in gated mode holds output at DC offset.
// - Bus, immediate or internal source in gated mode means external.
// - Immediate source in counted mode means external input.
// - Backplane selection picks one of eight lines, zero to seven.
module bfm_burst_fm_ctrl #(
    parameter int NLINES = 8
) (
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic                 devWrite,
    input  wire logic [bfm_pkg::FW-1:0] devRequest,
    input  wire logic [bfm_pkg::FW-1:0] carrierFreq,
    input  bfm_pkg::bfm_shape_t       shape,
    input  wire logic                 modWrite,
    input  bfm_pkg::bfm_mod_t         modRequest,
    input  wire logic                 burstEnableWrite,
    input  wire logic                 burstEnable,
    input  bfm_pkg::bfm_burst_cfg_t   burstCfg,
    input  wire logic                 extTrigger,
    input  wire logic [NLINES-1:0]    backplaneTrigger,
    input  wire logic                 busTrigger,
    input  wire logic                 cycleDone,
    output logic [bfm_pkg::FW-1:0]    peakDeviation,
    output logic                      conflictError,
    output logic [15:0]               errorCode,
    output bfm_pkg::bfm_mod_t         activeMod,
    output logic                      waveformOn,
    output logic                      holdOffset,
    output logic                      burstStart,
    output logic [bfm_pkg::PW-1:0]    startPhase
);
    if (NLINES != 2**bfm_pkg::LW)
    begin : g_bad_lines
        $error("NLINES must match the backplane line field width.");
    end

    // ------------------------------------------------------------
    // Deviation and modulation selection
    // ------------------------------------------------------------
    logic [bfm_pkg::FW-1:0] dev_reg, dev_next;
    logic                   cfl_reg, cfl_next;
    logic [15:0]            err_reg, err_next;
    bfm_pkg::bfm_mod_t      mod_reg, mod_next;
    logic [bfm_pkg::FW-1:0] limit;
    logic [bfm_pkg::FW-1:0] room;
    logic [bfm_pkg::FW-1:0] want;

    always_comb
    begin
        case (shape)
            bfm_pkg::SHP_TRI, bfm_pkg::SHP_RAMP: limit = bfm_pkg::LIM_TRI;
            bfm_pkg::SHP_ARB:                    limit = bfm_pkg::LIM_ARB;
            default:                             limit = bfm_pkg::LIM_SINE;
        endcase
        room = (carrierFreq < limit) ? limit - carrierFreq : '0;
        dev_next = dev_reg;
        cfl_next = 1'b0;
        err_next = err_reg;
        mod_next = mod_reg;
        want = devRequest;
        if (want < bfm_pkg::DEV_MIN)
            want = bfm_pkg::DEV_MIN;
        if (want > bfm_pkg::DEV_MAX)
            want = bfm_pkg::DEV_MAX;
        if (devWrite)
        begin
            if (mod_reg == bfm_pkg::MOD_FM && want > carrierFreq)
            begin
                want = carrierFreq;
                cfl_next = 1'b1;
            end
            if (want > room)
            begin
                want = room;
                cfl_next = 1'b1;
            end
            // Never below the legal floor, even when the carrier is too high.
            dev_next = (want < bfm_pkg::DEV_MIN) ? bfm_pkg::DEV_MIN : want;
        end
        if (cfl_next)
            err_next = bfm_pkg::ERR_CONFLICT;
        if (burstEnableWrite)
        begin
            if (burstEnable)
                mod_next = bfm_pkg::MOD_BURST;
            else if (mod_reg == bfm_pkg::MOD_BURST)
                mod_next = bfm_pkg::MOD_NONE;
        end
        else if (modWrite)
            mod_next = modRequest;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            dev_reg <= bfm_pkg::DEV_RESET;
            cfl_reg <= 1'b0;
            err_reg <= bfm_pkg::ERR_NONE;
            mod_reg <= bfm_pkg::MOD_NONE;
        end
        else
        begin
            dev_reg <= dev_next;
            cfl_reg <= cfl_next;
            err_reg <= err_next;
            mod_reg <= mod_next;
        end
    end

    // Two flops tame the pins; the third stage only feeds the edge detector.
    logic [NLINES:0] syncA;
    logic [NLINES:0] syncB;
    logic [NLINES:0] syncC;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            syncA <= '0;
            syncB <= '0;
            syncC <= '0;
        end
        else
        begin
            syncA <= {backplaneTrigger, extTrigger};
            syncB <= syncA;
            syncC <= syncB;
        end
    end

    // ------------------------------------------------------------
    // Burst engine
    // ------------------------------------------------------------
    bfm_pkg::bfm_state_t    st_reg, st_next;
    logic [bfm_pkg::CW-1:0] cnt_reg, cnt_next;
    logic [bfm_pkg::RW-1:0] tmr_reg, tmr_next;
    logic                   on_reg, on_next;
    logic                   hold_reg, hold_next;
    logic                   go_reg, go_next;
    logic [bfm_pkg::PW-1:0] ph_reg, ph_next;
    logic                   shapeOk, enabled, gated, useLine;
    logic                   level, rise, tick, trig;
    logic [bfm_pkg::CW-1:0] target;
    logic [bfm_pkg::RW-1:0] period;
    localparam int LW_IDX = bfm_pkg::LW + 1;
    logic [LW_IDX-1:0]      lineIdx;

    always_comb
    begin
        shapeOk = (shape != bfm_pkg::SHP_OTHER);
        enabled = (mod_reg == bfm_pkg::MOD_BURST) && shapeOk;
        gated = burstCfg.gatedMode;
        // gated substitutes external; immediate is external
        useLine = (burstCfg.triggerSourceSelect == bfm_pkg::TRG_BACKPLANE);
        lineIdx = {1'b0, burstCfg.backplaneTriggerLine} + 4'h1;
        level = useLine ? syncB[lineIdx] : syncB[0];
        rise = useLine ? (syncB[lineIdx] & ~syncC[lineIdx]) : (syncB[0] & ~syncC[0]);
        target = (burstCfg.burstCycleCount == '0) ? 24'h000001 : burstCfg.burstCycleCount;
        period = (burstCfg.burstRepeatRate == '0) ? 32'h00000001 : burstCfg.burstRepeatRate;
        // repetition timer; rate ignored off internal source
        tick = 1'b0;
        tmr_next = '0;
        if (enabled && !gated && burstCfg.triggerSourceSelect == bfm_pkg::TRG_INTERNAL)
        begin
            tick = (tmr_reg >= period - 32'h00000001);
            tmr_next = tick ? '0 : tmr_reg + 32'h00000001;
        end
        case (burstCfg.triggerSourceSelect)
            bfm_pkg::TRG_INTERNAL: trig = tick;
            bfm_pkg::TRG_BUS:      trig = busTrigger;
            default:               trig = rise;
        endcase
        st_next = st_reg;
        cnt_next = cnt_reg;
        go_next = 1'b0;
        ph_next = ph_reg;
        case (st_reg)
            bfm_pkg::BST_IDLE:
            begin
                if (enabled && gated && level)
                begin
                    st_next = bfm_pkg::BST_GATE;
                    ph_next = '0;
                end
                else if (enabled && !gated && trig)
                begin
                    st_next = bfm_pkg::BST_RUN;
                    cnt_next = '0;
                    go_next = 1'b1;
                    ph_next = burstCfg.burstStartPhase;
                end
            end
            bfm_pkg::BST_RUN:
            begin
                if (!enabled || gated)
                    st_next = bfm_pkg::BST_IDLE;
                else if (cycleDone)
                begin
                    cnt_next = cnt_reg + 24'h000001;
                    if (cnt_next >= target)
                        st_next = bfm_pkg::BST_IDLE;
                end
            end
            bfm_pkg::BST_GATE:
            begin
                if (!enabled || !gated || !level)
                    st_next = bfm_pkg::BST_IDLE;
            end
            default: st_next = bfm_pkg::BST_IDLE;
        endcase
        // Without burst the carrier runs freely.
        on_next = !enabled || (st_next != bfm_pkg::BST_IDLE);
        hold_next = enabled && gated && (st_next == bfm_pkg::BST_IDLE);
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            st_reg <= bfm_pkg::BST_IDLE;
            cnt_reg <= '0;
            tmr_reg <= '0;
            on_reg <= 1'b1;
            hold_reg <= 1'b0;
            go_reg <= 1'b0;
            ph_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            tmr_reg <= tmr_next;
            on_reg <= on_next;
            hold_reg <= hold_next;
            go_reg <= go_next;
            ph_reg <= ph_next;
        end
    end

    assign peakDeviation = dev_reg;
    assign conflictError = cfl_reg;
    assign errorCode = err_reg;
    assign activeMod = mod_reg;
    assign waveformOn = on_reg;
    assign holdOffset = hold_reg;
    assign burstStart = go_reg;
    assign startPhase = ph_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_dev_range;
        @(posedge clk) disable iff (reset)
        dev_reg >= bfm_pkg::DEV_MIN && dev_reg <= bfm_pkg::DEV_MAX;
    endproperty
    a_dev_range: assert property (p_dev_range) else $error("Deviation out of range.");
    property p_dev_reset;
        @(posedge clk) $fell(reset) |-> dev_reg == bfm_pkg::DEV_RESET;
    endproperty
    a_dev_reset: assert property (p_dev_reset) else $error("Deviation reset wrong.");
    property p_fm_clamp;
        @(posedge clk) disable iff (reset)
        devWrite && mod_reg == bfm_pkg::MOD_FM && devRequest > carrierFreq
        && carrierFreq >= bfm_pkg::DEV_MIN && devRequest <= bfm_pkg::DEV_MAX
        |=> cfl_reg && dev_reg <= $past(carrierFreq) && err_reg == bfm_pkg::ERR_CONFLICT;
    endproperty
    a_fm_clamp: assert property (p_fm_clamp)
        else $error("Deviation above carrier was not clamped.");
    property p_sum_limit;
        @(posedge clk) disable iff (reset)
        devWrite && carrierFreq + bfm_pkg::DEV_MIN <= limit
        |=> dev_reg + $past(carrierFreq) <= $past(limit);
    endproperty
    a_sum_limit: assert property (p_sum_limit)
        else $error("Carrier plus deviation exceeds the ceiling.");
    property p_burst_excl;
        @(posedge clk) disable iff (reset)
        burstEnableWrite && burstEnable |=> mod_reg == bfm_pkg::MOD_BURST;
    endproperty
    a_burst_excl: assert property (p_burst_excl) else $error("Burst did not take over.");
    property p_shape;
        @(posedge clk) disable iff (reset)
        !shapeOk |=> st_reg == bfm_pkg::BST_IDLE;
    endproperty
    a_shape: assert property (p_shape) else $error("Burst ran on an unsupported shape.");
    property p_count;
        @(posedge clk) disable iff (reset)
        st_reg == bfm_pkg::BST_RUN && enabled && !gated && cycleDone
        && cnt_reg + 24'h000001 >= target |=> st_reg == bfm_pkg::BST_IDLE && !on_reg;
    endproperty
    a_count: assert property (p_count) else $error("Burst did not stop on its count.");
    property p_gate_open;
        @(posedge clk) disable iff (reset)
        enabled && gated && level |=> on_reg && !hold_reg;
    endproperty
    a_gate_open: assert property (p_gate_open) else $error("Gate high left output off.");
    property p_gate_low;
        @(posedge clk) disable iff (reset)
        enabled && gated && !level |=> !on_reg && hold_reg;
    endproperty
    a_gate_low: assert property (p_gate_low) else $error("Gate low held no offset.");
    property p_timer;
        @(posedge clk) disable iff (reset)
        st_reg == bfm_pkg::BST_IDLE && enabled && !gated && tick |=> go_reg;
    endproperty
    a_timer: assert property (p_timer) else $error("Timer tick did not start a burst.");
endmodule // bfm_burst_fm_ctrl

/* verification/bfm_trig_src.sv */
// Trigger and gate source model that sits on the far side of the burst controller.
`timescale 1ns/10ps
module bfm_trig_src (
    input  wire logic       clk,
    input  wire logic       fireReq,
    input  wire logic       gateReq,
    input  wire logic       useLine,
    input  wire logic [2:0] lineSel,
    output logic            extTrigger,
    output logic [7:0]      backplaneTrigger
);
    // ------------------------------------------------------------
    // Pulse stretcher and line routing
    // ------------------------------------------------------------
    logic [2:0] pulseCnt_reg = 3'h0;
    logic [2:0] pulseCnt_next;
    logic       active;

    // A trigger edge is held for four clocks so the two-stage pin sync always sees it.
    always_comb
    begin
        pulseCnt_next = (pulseCnt_reg != 3'h0) ? pulseCnt_reg - 3'h1 : 3'h0;
        if (fireReq)
            pulseCnt_next = 3'h4;
    end

    always_ff @(posedge clk)
        pulseCnt_reg <= pulseCnt_next;

    always_comb
    begin
        active = gateReq || (pulseCnt_reg != 3'h0);
        extTrigger = !useLine && active;
        backplaneTrigger = 8'h00;
        backplaneTrigger[lineSel] = useLine && active;
    end
endmodule // bfm_trig_src

/* verification/bfm_burst_fm_ctrl_test.sv */
// Self-checking testbench for the burst and deviation controller.
`timescale 1ns/10ps
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin nErrors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module bfm_burst_fm_ctrl_test;
    logic                    clk;
    logic                    reset;
    logic                    devWrite, modWrite, burstEnableWrite, burstEnable;
    logic                    busTrigger, cycleDone, fireReq, gateReq, useLine;
    logic [2:0]              lineSel;
    logic [bfm_pkg::FW-1:0]  devRequest, carrierFreq, peakDeviation;
    bfm_pkg::bfm_shape_t     shape;
    bfm_pkg::bfm_mod_t       modRequest, activeMod;
    bfm_pkg::bfm_burst_cfg_t burstCfg;
    logic                    extTrigger, conflictError, waveformOn, holdOffset, burstStart;
    logic [7:0]              backplaneTrigger;
    logic [15:0]             errorCode;
    logic [11:0]             startPhase;
    int                      nErrors = 0;
    int                      nTests = 0;

    bfm_burst_fm_ctrl DUT (.clk(clk), .reset(reset), .devWrite(devWrite),
        .devRequest(devRequest), .carrierFreq(carrierFreq), .shape(shape),
        .modWrite(modWrite), .modRequest(modRequest), .burstEnableWrite(burstEnableWrite),
        .burstEnable(burstEnable), .burstCfg(burstCfg), .extTrigger(extTrigger),
        .backplaneTrigger(backplaneTrigger), .busTrigger(busTrigger), .cycleDone(cycleDone),
        .peakDeviation(peakDeviation), .conflictError(conflictError), .errorCode(errorCode),
        .activeMod(activeMod), .waveformOn(waveformOn), .holdOffset(holdOffset),
        .burstStart(burstStart), .startPhase(startPhase));

    bfm_trig_src source (.clk(clk), .fireReq(fireReq), .gateReq(gateReq), .useLine(useLine),
        .lineSel(lineSel), .extTrigger(extTrigger), .backplaneTrigger(backplaneTrigger));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic giveVerdict();
        if (nErrors == 0 && nTests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Polls after each edge so that one-cycle pulses are not missed.
    task automatic waitSig(input int which, input logic v, input int bound);
        int i;
        for (i = 0; i < bound; i++)
        begin
            #1;
            if ((which == 0 ? burstStart : which == 1 ? waveformOn : holdOffset) === v)
                break;
            @(posedge clk);
        end
        if (i == bound)
        begin
            nErrors++;
            giveVerdict();
        end
    endtask

    task automatic pulse(input int which);
        @(posedge clk);
        case (which)
            0: busTrigger <= 1'b1;
            1: fireReq <= 1'b1;
            default: cycleDone <= 1'b1;
        endcase
        @(posedge clk);
        busTrigger <= 1'b0;
        fireReq <= 1'b0;
        cycleDone <= 1'b0;
    endtask

    task automatic ctl(input int which, input logic v);
        @(posedge clk);
        if (which == 0)
            modWrite <= 1'b1;
        else
            burstEnableWrite <= 1'b1;
        burstEnable <= v;
        @(posedge clk);
        modWrite <= 1'b0;
        burstEnableWrite <= 1'b0;
        #1;
    endtask

    task automatic devCase(input logic [39:0] c, input bfm_pkg::bfm_shape_t s,
                           input logic [39:0] r, input logic [39:0] e, input logic conf);
        @(posedge clk);
        carrierFreq <= c;
        shape <= s;
        devRequest <= r;
        devWrite <= 1'b1;
        @(posedge clk);
        devWrite <= 1'b0;
        #1;
        `CHK(peakDeviation, e)
        `CHK(conflictError, conf)
    endtask

    task automatic runBurst(input bfm_pkg::bfm_trig_t src, input bfm_pkg::bfm_shape_t shp,
                            input logic [2:0] line);
        time t0;
        ctl(1, 1'b0);
        @(posedge clk);
        shape <= shp;
        burstCfg <= '{1'b0, src, line, 24'h3, 32'h14, {9'h05a, line}};
        useLine <= (src == bfm_pkg::TRG_BACKPLANE);
        lineSel <= line;
        ctl(1, 1'b1);
        `CHK(activeMod, bfm_pkg::MOD_BURST)
        if (src == bfm_pkg::TRG_BUS)
            pulse(0);
        else if (src != bfm_pkg::TRG_INTERNAL)
            pulse(1);
        waitSig(0, 1'b1, 40);
        t0 = $time;
        `CHK(waveformOn, 1'b1)
        `CHK(startPhase, {9'h05a, line})
        if (src == bfm_pkg::TRG_BUS)
            pulse(0);
        pulse(2);
        pulse(2);
        #1;
        `CHK(waveformOn, 1'b1)
        pulse(2);
        waitSig(1, 1'b0, 3);
        if (src == bfm_pkg::TRG_INTERNAL)
        begin
            waitSig(0, 1'b1, 30);
            `CHK(($time - t0) / 8, 64'h14)
        end
    endtask

    // ------------------------------------------------------------
    // Stimulus and checks
    // ------------------------------------------------------------
    initial
    begin
        reset = 1'b1;
        {devWrite, modWrite, burstEnableWrite, burstEnable} = 4'h0;
        {busTrigger, cycleDone, fireReq, gateReq, useLine} = 5'h00;
        lineSel = 3'h0;
        devRequest = 40'h0;
        carrierFreq = 40'h0;
        shape = bfm_pkg::SHP_SINE;
        modRequest = bfm_pkg::MOD_FM;
        burstCfg = '0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        #1;
        `CHK(peakDeviation, bfm_pkg::DEV_RESET)
        `CHK(errorCode, 16'h0000)
        `CHK(activeMod, bfm_pkg::MOD_NONE)
        `CHK(waveformOn, 1'b1)
        ctl(0, 1'b0);
        `CHK(activeMod, bfm_pkg::MOD_FM)
        devCase(40'h0f4240, bfm_pkg::SHP_SINE, 40'h07a120, 40'h07a120, 1'b0);
        devCase(40'h0f4240, bfm_pkg::SHP_SINE, 40'h1e8480, 40'h0f4240, 1'b1);
        `CHK(errorCode, 16'hff23)
        devCase(40'h0f4240, bfm_pkg::SHP_SINE, 40'h5, bfm_pkg::DEV_MIN, 1'b0);
        devCase(bfm_pkg::LIM_SINE - bfm_pkg::DEV_MAX, bfm_pkg::SHP_SQUARE,
                bfm_pkg::DEV_MAX + 40'h1, bfm_pkg::DEV_MAX, 1'b0);
        devCase(bfm_pkg::LIM_SINE - 40'h0f4240, bfm_pkg::SHP_SQUARE,
                40'h1e8480, 40'h0f4240, 1'b1);
        devCase(bfm_pkg::LIM_TRI - 40'h0f4240, bfm_pkg::SHP_RAMP,
                40'h1e8480, 40'h0f4240, 1'b1);
        devCase(bfm_pkg::LIM_ARB - 40'h0f4240, bfm_pkg::SHP_ARB,
                40'h1e8480, 40'h0f4240, 1'b1);
        // Every shape that may burst gets one trial, each with a different trigger source.
        runBurst(bfm_pkg::TRG_BUS, bfm_pkg::SHP_SINE, 3'h0);
        runBurst(bfm_pkg::TRG_EXTERNAL, bfm_pkg::SHP_SQUARE, 3'h1);
        runBurst(bfm_pkg::TRG_BACKPLANE, bfm_pkg::SHP_TRI, 3'h5);
        runBurst(bfm_pkg::TRG_IMMEDIATE, bfm_pkg::SHP_RAMP, 3'h2);
        runBurst(bfm_pkg::TRG_INTERNAL, bfm_pkg::SHP_ARB, 3'h3);
        @(posedge clk);
        burstCfg <= '{1'b1, bfm_pkg::TRG_BUS, 3'h0, 24'h3, 32'h14, 12'h123};
        useLine <= 1'b0;
        ctl(1, 1'b1);
        waitSig(2, 1'b1, 8);
        `CHK(waveformOn, 1'b0)
        @(posedge clk);
        gateReq <= 1'b1;
        waitSig(1, 1'b1, 8);
        `CHK(holdOffset, 1'b0)
        `CHK(startPhase, 12'h000)
        @(posedge clk);
        gateReq <= 1'b0;
        waitSig(1, 1'b0, 8);
        `CHK(holdOffset, 1'b1)
        @(posedge clk);
        burstCfg <= '{1'b1, bfm_pkg::TRG_BACKPLANE, 3'h7, 24'h3, 32'h14, 12'h123};
        useLine <= 1'b1;
        lineSel <= 3'h6;
        gateReq <= 1'b1;
        repeat (6) @(posedge clk);
        #1;
        `CHK(waveformOn, 1'b0)
        @(posedge clk);
        lineSel <= 3'h7;
        waitSig(1, 1'b1, 8);
        `CHK(holdOffset, 1'b0)
        // A shape that cannot burst must ignore a trigger and let the carrier run.
        @(posedge clk);
        shape <= bfm_pkg::SHP_OTHER;
        burstCfg <= '{1'b0, bfm_pkg::TRG_BUS, 3'h0, 24'h3, 32'h14, 12'h123};
        pulse(0);
        #1;
        `CHK(burstStart, 1'b0)
        `CHK(waveformOn, 1'b1)
        giveVerdict();
    end
endmodule // bfm_burst_fm_ctrl_test
